/* src/aps_device.sv */
// Converter end: power-down, nap, conversion and serial result shifting.
// Assumes host pins are asynchronous; all of them are synchronised here.
// Assumes sample_i is steady by the end of each conversion.
//
// How it works
// - Shutdown high enters full power-down
// - Power-down within 10 us, output three-stated
// - Shutdown low resumes operation
// - First two results after resume flagged inaccurate
// - Host waits 25 ms resume time
// - Host waits further 4 ms after trims
// - Qualifier low at end: nap within 200 ns
// - Host picks nap per conversion via qualifier
// - Host lengthens sampling after nap
// - Host reads back-to-back, frame sync high
// - Device restarts a read on a frame sync rise; host holds it high
// - Result is 18-bit two's complement, serial
`timescale 1ns/1ps
module aps_device
    import aps_pkg::*;
#(
    parameter int unsigned W = RESULT_W
) (
    // Clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         rst_b_i,
    // Link
    aps_link_if.dev           link,
    // Analog core stand-in
    input  wire logic [W-1:0] sample_i,
    // Status
    output logic              napping_o,
    output logic              powered_down_o,
    output logic              trim_loading_o
);

    // Two flops per pin; only the second is read by logic
    logic [1:0] pd_s, cv_s, q_s, fs_s, ck_s;
    logic       cv_d, ck_d, fs_d;

    // Shutdown is a level; acted on as soon as the second flop sees it
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pd_s <= 2'h0;
        end else begin
            pd_s <= {pd_s[0], link.shutdown_input};
        end
    end

    // Convert start; only its rising edge starts a conversion
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cv_s <= 2'h0;
            cv_d <= 1'b0;
        end else begin
            cv_s <= {cv_s[0], link.convert_start};
            cv_d <= cv_s[1];
        end
    end

    // Qualifier level, only read at end of conversion
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q_s <= 2'h3;
        end else begin
            q_s <= {q_s[0], link.conversion_qualifier};
        end
    end

    // Frame sync idles high; reset high so no false edge follows reset
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fs_s <= 2'h3;
            fs_d <= 1'b1;
        end else begin
            fs_s <= {fs_s[0], link.frame_sync};
            fs_d <= fs_s[1];
        end
    end

    // Serial clock idles low; one shift per synced rising edge
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ck_s <= 2'h0;
            ck_d <= 1'b0;
        end else begin
            ck_s <= {ck_s[0], link.sclk};
            ck_d <= ck_s[1];
        end
    end

    // Synced levels and edges; each acts three edges after its pin
    wire pd       = pd_s[1];
    wire cv_rise  = cv_s[1] & ~cv_d;
    wire ck_rise  = ck_s[1] & ~ck_d;
    wire fs_rise  = fs_s[1] & ~fs_d;

    // Conversion state and result path
    aps_state_t           state_reg;
    logic [7:0]           conv_cnt_reg;
    logic [1:0]           trim_cnt_reg;
    logic [W-1:0]         shift_reg;
    logic [W-1:0]         result_reg;
    logic                 end_conv;

    // Last timer count; busy falls on the following edge
    assign end_conv = (state_reg == APS_CONV) && (conv_cnt_reg == 8'(CONV_CYC - 1));

    // Power-down takes a few cycles of sync, well inside the limit
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= APS_RUN;
        end else begin
            case (state_reg)
                APS_RUN, APS_NAP: begin
                    if (pd) begin
                        state_reg <= APS_DOWN;
                    end else if (cv_rise) begin
                        state_reg <= APS_CONV;
                    end
                end
                APS_CONV: begin
                    if (pd) begin
                        state_reg <= APS_DOWN;
                    end else if (end_conv) begin
                        state_reg <= q_s[1] ? APS_RUN : APS_NAP;
                    end
                end
                // Starts and serial clock are ignored while down
                APS_DOWN: begin
                    if (!pd) begin
                        state_reg <= APS_RUN;
                    end
                end
                default: state_reg <= APS_RUN;
            endcase
        end
    end

    // Conversion timer; cleared outside a conversion, so an aborted one
    // leaves nothing behind for the next start
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            conv_cnt_reg <= 8'h00;
        end else if (state_reg != APS_CONV) begin
            conv_cnt_reg <= 8'h00;
        end else if (!end_conv) begin
            conv_cnt_reg <= conv_cnt_reg + 8'h01;
        end
    end

    // Trim reload spans the first conversions after resume
    // A conversion cut short by shutdown never counts
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trim_cnt_reg <= 2'h0;
        end else if (state_reg == APS_DOWN) begin
            trim_cnt_reg <= 2'(TRIM_CONVS);
        end else if (end_conv && trim_cnt_reg != 2'h0) begin
            trim_cnt_reg <= trim_cnt_reg - 2'h1;
        end
    end

    // Last result kept so a frame sync rise can restart the read
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            result_reg <= '0;
        end else if (end_conv) begin
            result_reg <= sample_i;
        end
    end

    // MSB first; a frame sync rise reloads the last result
    // Shifting is frozen while powered down
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shift_reg <= '0;
        end else if (state_reg == APS_DOWN) begin
            shift_reg <= shift_reg;
        end else if (end_conv) begin
            shift_reg <= sample_i;
        end else if (fs_rise) begin
            shift_reg <= result_reg;
        end else if (ck_rise) begin
            shift_reg <= {shift_reg[W-2:0], 1'b0};
        end
    end

    assign link.serial_out_o  = shift_reg[W-1];
    // Nap keeps the output driven; only full power-down releases it
    assign link.serial_out_oe = (state_reg != APS_DOWN);
    assign link.busy          = (state_reg == APS_CONV);

    // Status registered so user logic sees clean levels
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            napping_o      <= 1'b0;
            powered_down_o <= 1'b0;
            trim_loading_o <= 1'b0;
        end else begin
            napping_o      <= (state_reg == APS_NAP);
            powered_down_o <= (state_reg == APS_DOWN);
            trim_loading_o <= (trim_cnt_reg != 2'h0);
        end
    end

endmodule

/* src/aps_pkg.sv */
// Constants and types shared by both ends of the converter power-save link.
// Assumes a single 40 MHz reference clock on both ends.
package aps_pkg;

    localparam int unsigned CLK_PERIOD_PS = 25000;

    localparam int unsigned PD_ENTRY_NS    = 10000;
    localparam int unsigned NAP_ENTRY_NS   = 200;
    localparam int unsigned RESUME_US      = 25000;
    localparam int unsigned REF_SETTLE_US  = 4000;
    localparam int unsigned CONV_TIME_NS   = 1100;

    // Longest times round down, least times round up
    localparam int unsigned PD_ENTRY_CYC   = (PD_ENTRY_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned NAP_ENTRY_CYC  = (NAP_ENTRY_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned CONV_CYC       = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned RESUME_CYC     = (RESUME_US * 40);
    localparam int unsigned REF_SETTLE_CYC = (REF_SETTLE_US * 40);

    localparam int unsigned RESULT_W       = 18;
    localparam int unsigned TRIM_CONVS     = 2;

    typedef enum logic [1:0] {
        APS_RUN  = 2'b00,
        APS_CONV = 2'b01,
        APS_NAP  = 2'b10,
        APS_DOWN = 2'b11
    } aps_state_t;

endpackage

/* src/aps_link_if.sv */
// Pins between the converter and its host controller.
// Serial output is three-state: the enable low marks the released pin.
`timescale 1ns/1ps
interface aps_link_if;
    logic shutdown_input;
    logic convert_start;
    logic conversion_qualifier;
    logic frame_sync;
    logic sclk;
    logic serial_out_o;
    logic serial_out_oe;
    logic busy;

    modport dev (
        input  shutdown_input, convert_start, conversion_qualifier, frame_sync, sclk,
        output serial_out_o, serial_out_oe, busy
    );
    modport host (
        output shutdown_input, convert_start, conversion_qualifier, frame_sync, sclk,
        input  serial_out_o, serial_out_oe, busy
    );
endinterface

/* src/aps_host.sv */
// Host end: drives shutdown, convert start, qualifier, frame sync and serial clock.
// Assumes the converter shares ref_clk_i; busy is still synchronised.
`timescale 1ns/1ps
module aps_host
    import aps_pkg::*;
#(
    parameter int unsigned W          = RESULT_W,
    parameter int unsigned RESUME     = RESUME_CYC,
    parameter int unsigned SETTLE     = REF_SETTLE_CYC,
    parameter int unsigned NAP_EXTRA  = 8
) (
    // Clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         rst_b_i,
    // Link
    aps_link_if.host          link,
    // User side
    input  wire logic         shutdown_req_i,
    input  wire logic         convert_req_i,
    input  wire logic         nap_after_i,
    output logic              ready_o,
    output logic [W-1:0]      result_o,
    output logic              result_valid_o,
    output logic              result_trusted_o
);

    logic [1:0]  busy_s, sdo_s;
    logic        busy_d;
    logic        pd_reg, cv_reg, q_reg, ck_reg, napped_reg;
    logic [5:0]  bit_reg;
    logic [2:0]  ph_reg;
    logic [31:0] wait_reg;
    logic [1:0]  trim_reg;
    logic [W-1:0] res_reg;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_s <= 2'h0;
            sdo_s  <= 2'h0;
            busy_d <= 1'b0;
        end else begin
            busy_s <= {busy_s[0], link.busy};
            sdo_s  <= {sdo_s[0], link.serial_out_o & link.serial_out_oe};
            busy_d <= busy_s[1];
        end
    end

    wire eoc = busy_d & ~busy_s[1];

    // Waits out resume or the settle time after the trim conversions, whichever ends later
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pd_reg   <= 1'b0;
            wait_reg <= 32'h0;
            trim_reg <= 2'h0;
        end else begin
            pd_reg <= shutdown_req_i;
            if (pd_reg) begin
                wait_reg <= 32'(RESUME);
                trim_reg <= 2'(TRIM_CONVS);
            end else if (trim_reg != 2'h0 && eoc) begin
                trim_reg <= trim_reg - 2'h1;
                if (trim_reg == 2'h1 && wait_reg < 32'(SETTLE)) begin
                    wait_reg <= 32'(SETTLE);
                end
            end else if (wait_reg != 32'h0) begin
                wait_reg <= wait_reg - 32'h1;
            end
        end
    end

    // Not ready in the end-of-conversion cycle, while the readout is armed
    assign ready_o = !pd_reg && !cv_reg && !busy_s[1] && bit_reg == 6'h00 && !eoc;

    // Convert pulse, qualifier choice and nap recovery padding
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cv_reg     <= 1'b0;
            q_reg      <= 1'b1;
            napped_reg <= 1'b0;
        end else begin
            if (eoc) begin
                napped_reg <= !q_reg;
            end
            if (ready_o && convert_req_i && !napped_reg) begin
                cv_reg <= 1'b1;
                q_reg  <= !nap_after_i;
            end else if (cv_reg && busy_s[1]) begin
                cv_reg <= 1'b0;
            end else if (ready_o && convert_req_i && napped_reg) begin
                napped_reg <= 1'b0;                                  // extra sampling cycle
            end
        end
    end

    // Read 18 bits after each conversion, frame sync held high
    // Eight cycles a bit: device shift plus both sync stages take five
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bit_reg        <= 6'h00;
            ph_reg         <= 3'h0;
            ck_reg         <= 1'b0;
            res_reg        <= '0;
            result_o       <= '0;
            result_valid_o <= 1'b0;
        end else begin
            result_valid_o <= 1'b0;
            if (eoc) begin
                bit_reg <= 6'(W);
                ph_reg  <= 3'h0;
                ck_reg  <= 1'b0;
            end else if (bit_reg != 6'h00) begin
                ph_reg <= ph_reg + 3'h1;
                ck_reg <= (ph_reg == 3'h0) && (bit_reg != 6'h01);
                if (ph_reg == 3'h0) begin
                    res_reg <= {res_reg[W-2:0], sdo_s[1]};
                    bit_reg <= bit_reg - 6'h01;
                    if (bit_reg == 6'h01) begin
                        result_o       <= {res_reg[W-2:0], sdo_s[1]};
                        result_valid_o <= 1'b1;
                    end
                end
            end
        end
    end

    assign result_trusted_o         = (wait_reg == 32'h0) && (trim_reg == 2'h0);
    assign link.shutdown_input       = pd_reg;
    assign link.convert_start        = cv_reg;
    assign link.conversion_qualifier = q_reg;
    assign link.frame_sync           = 1'b1;                         // fixed back-to-back mode, frame sync held high
    assign link.sclk                 = ck_reg;

endmodule

/* bench/aps_properties.sv */
// Link-level checks between converter and host ends.
// Assumes one shared clock; sees only the interface pins.
`timescale 1ns/1ps
module aps_properties (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Link pins
    input wire logic shutdown_input,
    input wire logic convert_start,
    input wire logic conversion_qualifier,
    input wire logic frame_sync,
    input wire logic sclk,
    input wire logic serial_out_o,
    input wire logic serial_out_oe,
    input wire logic busy
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_down_tristate: assert property (shutdown_input [*8] |-> !serial_out_oe)
        else $error("output still driven in power-down");
    a_run_driven: assert property (!shutdown_input [*8] |-> serial_out_oe)
        else $error("output released outside power-down");
    a_down_no_busy: assert property (shutdown_input [*8] |-> !busy)
        else $error("conversion running in power-down");
    a_down_frozen: assert property (shutdown_input [*8] |-> $stable(serial_out_o))
        else $error("serial data moved in power-down");
    a_conv_response: assert property (!shutdown_input [*8] ##1 $rose(convert_start) |-> ##[1:8] busy)
        else $error("convert start not answered");
    a_conv_span: assert property ($fell(busy) && !shutdown_input |-> $past(busy, 43))
        else $error("conversion ended early");
    a_nap_driven: assert property ($fell(busy) && !conversion_qualifier |=> serial_out_oe [*8])
        else $error("output released in nap");
    a_frame_high: assert property (frame_sync)
        else $error("frame sync left high level");

    c_nap: cover property ($fell(busy) && !conversion_qualifier);
    c_down: cover property ($fell(serial_out_oe));
    c_conv: cover property ($rose(busy));
endmodule

/* bench/adc_power_save_control_bench.sv */
// Self-checking bench: host and converter ends joined by the link.
// Assumes shortened resume and settle counts on the host.
`timescale 1ns/1ps
module adc_power_save_control_bench;
    import aps_pkg::*;
    localparam int RES = 50;
    localparam int SET = 20;
    logic                ref_clk_i      = 1'h0;
    logic                rst_b_i        = 1'h0;
    logic                shutdown_req_i = 1'h0;
    logic                convert_req_i  = 1'h0;
    logic                nap_after_i    = 1'h0;
    logic [RESULT_W-1:0] sample_i       = 18'h00000;
    logic [RESULT_W-1:0] result_o;
    logic                ready_o, result_valid_o, result_trusted_o;
    logic                napping_o, powered_down_o, trim_loading_o;
    int                  err_total      = 0;
    int                  compares       = 0;

    aps_link_if link ();
    aps_device aps_device_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .link(link), .sample_i(sample_i),
        .napping_o(napping_o), .powered_down_o(powered_down_o), .trim_loading_o(trim_loading_o));
    aps_host #(.RESUME(RES), .SETTLE(SET)) aps_host_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .link(link), .shutdown_req_i(shutdown_req_i), .convert_req_i(convert_req_i), .nap_after_i(nap_after_i),
        .ready_o(ready_o), .result_o(result_o), .result_valid_o(result_valid_o),
        .result_trusted_o(result_trusted_o));
    aps_properties aps_properties_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .shutdown_input(link.shutdown_input), .convert_start(link.convert_start),
        .conversion_qualifier(link.conversion_qualifier), .frame_sync(link.frame_sync), .sclk(link.sclk),
        .serial_out_o(link.serial_out_o), .serial_out_oe(link.serial_out_oe), .busy(link.busy));

    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'h1) begin
            err_total++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask

    task automatic conclude;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Request held until busy, so a nap-clearing accept still converts
    task automatic conv(input logic [RESULT_W-1:0] v, input logic nap, input logic trim);
        int n;
        @(negedge ref_clk_i);
        chk(trim_loading_o === trim, "trim flag");
        sample_i = v;
        nap_after_i = nap;
        convert_req_i = 1'h1;
        for (n = 0; n < 300 && link.busy !== 1'h1; n++) @(negedge ref_clk_i);
        convert_req_i = 1'h0;
        for (n = 0; n < 300 && result_valid_o !== 1'h1; n++) @(negedge ref_clk_i);
        chk(result_o === v, "result word");
    endtask

    task automatic t_codes;
        logic [RESULT_W-1:0] codes [4] = '{18'h1FFFF, 18'h20000, 18'h3FFFF, 18'h00001};
        foreach (codes[i]) begin
            conv(codes[i], 1'h0, 1'h0);
            chk(napping_o === 1'h0, "nap with qualifier high");
        end
    endtask

    task automatic t_nap;
        conv(18'h15555, 1'h1, 1'h0);
        chk(napping_o === 1'h1, "no nap");
        chk(link.serial_out_oe === 1'h1, "output released in nap");
        conv(18'h2AAAA, 1'h0, 1'h0);
        chk(napping_o === 1'h0, "nap kept");
    endtask

    // Shutdown lands mid-conversion to exercise the abort
    task automatic t_down;
        int n;
        @(negedge ref_clk_i);
        convert_req_i = 1'h1;
        for (n = 0; n < 300 && link.busy !== 1'h1; n++) @(negedge ref_clk_i);
        convert_req_i = 1'h0;
        shutdown_req_i = 1'h1;
        for (n = 0; n < 400 && powered_down_o !== 1'h1; n++) @(negedge ref_clk_i);
        chk(powered_down_o === 1'h1, "no power-down");
        chk(link.serial_out_oe === 1'h0, "output driven");
        chk(link.busy === 1'h0, "conversion not aborted");
        repeat (20) @(negedge ref_clk_i);
        shutdown_req_i = 1'h0;
        for (n = 0; n < 400 && powered_down_o !== 1'h0; n++) @(negedge ref_clk_i);
        chk(powered_down_o === 1'h0, "no resume");
        conv(18'h0ABCD, 1'h0, 1'h1);
        chk(result_trusted_o === 1'h0, "first result trusted");
        conv(18'h35432, 1'h0, 1'h1);
        chk(trim_loading_o === 1'h0, "trim reload stuck");
        for (n = 0; n < RES + SET + 300 && result_trusted_o !== 1'h1; n++) @(negedge ref_clk_i);
        chk(result_trusted_o === 1'h1, "never trusted");
        conv(18'h1F0F0, 1'h0, 1'h0);
    endtask

    initial begin
        repeat (16) @(negedge ref_clk_i);
        rst_b_i = 1'h1;
        t_codes();
        t_nap();
        t_down();
        conclude();
    end

    // Whole run needs a few thousand cycles
    initial begin
        repeat (30000) @(posedge ref_clk_i);
        err_total++;
        conclude();
    end
endmodule
